// *** sic_pkg.sv ***
// constants, types and state record for the supply input conditioning block
package sic_pkg;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_HZ      = 40_000_000;
  localparam int TICK_NS     = 1000;
  localparam int TICK_CYC    = (CLK_HZ / 1_000_000) * TICK_NS / 1000;
  localparam int FILT_MAX_US = 100;
  localparam int PW_MAX_US   = 100;
  localparam int OCLK_HZ     = 100_000;
  localparam int OCLK_HALF   = CLK_HZ / (2 * OCLK_HZ);

  // ****************************************************
  // sizes
  // ****************************************************
  localparam int N_IN   = 10;
  localparam int N_VX   = 5;
  localparam int N_FLT  = 25;
  localparam int N_PDO  = 10;
  localparam int N_HD   = 6;
  localparam int N_SYNC = 26;

  // ****************************************************
  // register map (byte addresses)
  // ****************************************************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STAT   = 8'h04;
  localparam logic [7:0] A_INCFG  = 8'h40;
  localparam logic [7:0] A_PWID   = 8'h80;
  localparam logic [7:0] A_OUTCFG = 8'hC0;

  // input config fields
  localparam int F_UV = 0;
  localparam int F_OV = 8;
  localparam int F_HY = 16;
  localparam int F_FT = 21;
  localparam int F_LG = 28;
  localparam int F_ED = 29;
  localparam int F_PD = 30;
  // output config fields
  localparam int F_OM = 0;
  localparam int F_OS = 4;
  localparam int F_OB = 8;

  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [1:0]  R_OKAY  = 2'h0;
  localparam logic [1:0]  R_SLV   = 2'h2;

  typedef enum logic [2:0] {
    PM_OD, PM_WPU_VDD, PM_SPU_VDD, PM_WPU_VP,
    PM_SPU_VP, PM_SPD, PM_HD
  } pmode_e;

  typedef enum logic [1:0] {SRC_SE, SRC_BUS, SRC_CLK} src_e;

  typedef struct packed {
    logic [N_SYNC-1:0]      s1;
    logic [N_SYNC-1:0]      s2;
    logic [N_FLT-1:0]       fo;
    logic [N_FLT-1:0][6:0]  fc;
    logic [5:0]             tk;
    logic                   tick;
    logic [7:0]             ck;
    logic                   clk100;
    logic [N_VX-1:0]        fe;
    logic [N_VX-1:0][6:0]   pc;
    logic [N_VX-1:0]        lo;
    logic [N_IN-1:0]        flt;
    logic [N_VX-1:0]        wrn;
    logic                   wany;
    logic [N_IN-1:0][7:0]   uvt;
    logic [N_IN-1:0][7:0]   ovt;
    logic [N_IN-1:0][31:0]  icfg;
    logic [N_VX-1:0][6:0]   pw;
    logic [N_PDO-1:0][8:0]  ocfg;
    logic                   ctl;
    logic                   act;
    pmode_e [N_PDO-1:0]     pm;
    logic [N_PDO-1:0]       pdat;
    logic [N_VX-1:0]        pd;
    logic [7:0]             awa;
    logic                   awh;
    logic [31:0]            wd;
    logic [3:0]             ws;
    logic                   wh;
    logic                   bv;
    logic [1:0]             br;
    logic                   rv;
    logic [31:0]            rd;
    logic [1:0]             rr;
  } st_s;

endpackage

// *** supply_input_conditioning.sv ***
// supply input conditioning and output source selection with AXI4-Lite regs
//
// Overview of operation
// [RULE1] uv fault stays set until input exceeds uv threshold plus hysteresis
// [RULE2] ov fault stays set until input falls below ov threshold less hyst
// [RULE3] hysteresis is a 5-bit code, at most 31, on the threshold scale
// [RULE4] every detector ends in a glitch filter after the hysteresis
// [RULE5] filter timeout per input is programmable from 0 to 100 us
// [RULE6] pulses shorter than the timeout vanish, longer ones pass
// [RULE7] passed transitions come out delayed by the timeout
// [RULE8] software should give the first positive input a nonzero filter
// [RULE9] dual inputs as fault detectors have one low input range
// [RULE10] logic-mode dual input lends its detector to the paired input
// [RULE11] secondary detectors share the primary range and flag warnings
// [RULE12] warnings are readable in status and ORed to the engine
// [RULE13] logic inputs detect level or edge and feed the engine
// [RULE14] level mode outputs a copy of the filtered input
// [RULE15] edge mode emits one pulse per transition, width 0 to 100 us
// [RULE16] logic inputs use the same glitch filter as fault detectors
// [RULE17] logic inputs have a selectable weak pull-down
// [RULE18] outputs pick one of seven drive modes, high drive on 1-6 only
// [RULE19] output data comes from engine, bus bit or on-chip clock
// [RULE20] a 100 kHz on-chip clock may be routed to any output
// [RULE21] all configuration resets to zero, outputs weakly pulled low
// [RULE22] outputs follow configuration only after supply ok and latch
// [RULE23] thresholds are 8-bit codes on the range scale
// [RULE24] a dual input in fault mode is not a logic input, and back
// [RULE25] filter and pulse timers count 1 us oscillator ticks
// [RULE26] hysteresis picks raw or adjusted threshold by fault state
`timescale 1ns/1ps

module supply_input_conditioning (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_arst_n,
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [7:0]            i_awaddr,
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  output logic [1:0]                 o_bresp,
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  input  wire logic [7:0]            i_araddr,
  output logic                       o_rvalid,
  input  wire logic                  i_rready,
  output logic [31:0]                o_rdata,
  output logic [1:0]                 o_rresp,
  input  wire logic [9:0]            i_uv_cmp,
  input  wire logic [9:0]            i_ov_cmp,
  input  wire logic [4:0]            i_vx_pin,
  input  wire logic                  i_supply_ok,
  input  wire logic [9:0]            i_se_data,
  output logic [9:0][7:0]            o_uv_thr,
  output logic [9:0][7:0]            o_ov_thr,
  output logic [9:0]                 o_fault,
  output logic [4:0]                 o_warn,
  output logic                       o_warn_any,
  output logic [4:0]                 o_logic,
  output logic [4:0]                 o_vx_pd,
  output logic [9:0][2:0]            o_pdo_mode,
  output logic [9:0]                 o_pdo_data
);

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [4:0] hit(
    input logic [7:0] a,
    input logic [7:0] b,
    input int         n
  );
    logic [5:0] o;
    o = a[7:2] - b[7:2];
    hit = {(a >= b) && (int'(o) < n), o[3:0]};
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  st
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // timeout clamps at the documented maximum
  function automatic logic [6:0] lim(input logic [31:0] c);
    logic [6:0] t;
    t = c[sic_pkg::F_FT +: 7];
    lim = (t > 7'(sic_pkg::FILT_MAX_US)) ?
          7'(sic_pkg::FILT_MAX_US) : t;
  endfunction

  function automatic logic [7:0] sadd(
    input logic [7:0] u,
    input logic [4:0] h
  );
    logic [8:0] s;
    s = {1'b0, u} + {4'h0, h};
    sadd = s[8] ? 8'hFF : s[7:0];
  endfunction

  function automatic logic [7:0] ssub(
    input logic [7:0] u,
    input logic [4:0] h
  );
    ssub = (u < {3'h0, h}) ? 8'h00 : u - {3'h0, h};
  endfunction

  // filter f: 0-9 uv, 10-19 ov, 20-24 logic of dual inputs
  function automatic int cix(input int f);
    cix = (f < 10) ? f : ((f < 20) ? f - 10 : f - 15);
  endfunction

  sic_pkg::st_s q;
  sic_pkg::st_s d;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    logic [6:0]  lm;
    logic [4:0]  h;
    logic [31:0] w;
    logic [2:0]  m;
    logic        a;
    logic        lg;
    lm = 7'h00;
    h  = 5'h00;
    w  = 32'h0000_0000;
    m  = 3'h0;
    a  = 1'b0;
    lg = 1'b0;
    d  = q;

    d.s1 = {i_supply_ok, i_vx_pin, i_ov_cmp, i_uv_cmp};
    d.s2 = q.s1;

    // 1 us tick; coarse enough for 100 us with 7-bit counters
    d.tick = 1'b0;
    if (q.tk == 6'(sic_pkg::TICK_CYC - 1)) begin // RULE25
      d.tk   = 6'h00;
      d.tick = 1'b1;
    end else begin
      d.tk = q.tk + 6'h01;
    end

    if (q.ck == 8'(sic_pkg::OCLK_HALF - 1)) begin // RULE20
      d.ck     = 8'h00;
      d.clk100 = ~q.clk100;
    end else begin
      d.ck = q.ck + 8'h01;
    end

    // glitch filters: output moves only after the input held
    // its new level for the whole timeout
    for (int f = 0; f < sic_pkg::N_FLT; f++) begin // RULE4 RULE16
      lm = lim(q.icfg[cix(f)]); // RULE5
      if (q.s2[f] == q.fo[f]) begin
        d.fc[f] = 7'h00; // RULE6
      end else if (lm == 7'h00) begin
        d.fo[f] = q.s2[f]; // RULE5
      end else if (q.tick) begin
        if (q.fc[f] >= lm) begin
          d.fo[f] = q.s2[f]; // RULE7
          d.fc[f] = 7'h00;
        end else begin
          d.fc[f] = q.fc[f] + 7'h01;
        end
      end
    end

    // logic inputs
    for (int k = 0; k < sic_pkg::N_VX; k++) begin // RULE13
      lg      = q.icfg[5+k][sic_pkg::F_LG];
      d.fe[k] = q.fo[20+k];
      if (!lg) begin
        d.lo[k] = 1'b0; // RULE24
      end else if (!q.icfg[5+k][sic_pkg::F_ED]) begin
        d.lo[k] = q.fo[20+k]; // RULE14
      end else if (q.fo[20+k] != q.fe[k]) begin
        d.lo[k] = 1'b1; // RULE15
        d.pc[k] = 7'h00;
      end else if (q.lo[k]) begin
        if (q.pw[k] == 7'h00) begin
          d.lo[k] = 1'b0;
        end else if (q.tick) begin
          if (q.pc[k] >= q.pw[k]) begin
            d.lo[k] = 1'b0;
          end else begin
            d.pc[k] = q.pc[k] + 7'h01;
          end
        end
      end
      d.pd[k] = lg & q.icfg[5+k][sic_pkg::F_PD]; // RULE17
    end

    // faults and warnings
    for (int c = 0; c < sic_pkg::N_IN; c++) begin
      a = q.fo[c] | q.fo[10+c];
      if (c < sic_pkg::N_VX) begin
        d.flt[c] = a;
      end else begin
        lg           = q.icfg[c][sic_pkg::F_LG];
        d.flt[c]     = a & ~lg; // RULE24
        d.wrn[c-5]   = a & lg; // RULE10 RULE11
      end
    end
    d.wany = |d.wrn; // RULE12

    // threshold codes to the comparators; dual inputs in
    // fault mode only ever see the low range scale
    for (int c = 0; c < sic_pkg::N_IN; c++) begin // RULE9 RULE23
      d.uvt[c] = q.fo[c] ? // RULE26
                 sadd(q.icfg[c][sic_pkg::F_UV +: 8],
                      q.icfg[c][sic_pkg::F_HY +: 5]) : // RULE1 RULE3
                 q.icfg[c][sic_pkg::F_UV +: 8];
      d.ovt[c] = q.fo[10+c] ?
                 ssub(q.icfg[c][sic_pkg::F_OV +: 8],
                      q.icfg[c][sic_pkg::F_HY +: 5]) : // RULE2
                 q.icfg[c][sic_pkg::F_OV +: 8];
    end

    // output drivers
    d.act = q.ctl & q.s2[25]; // RULE22
    for (int j = 0; j < sic_pkg::N_PDO; j++) begin
      m = q.ocfg[j][sic_pkg::F_OM +: 3];
      if (!d.act || (m > 3'h6) ||
          ((m == 3'h6) && (j >= sic_pkg::N_HD))) begin // RULE18
        m = 3'h0; // RULE21
      end
      d.pm[j] = sic_pkg::pmode_e'(m);
      case (sic_pkg::src_e'(q.ocfg[j][sic_pkg::F_OS +: 2])) // RULE19
        sic_pkg::SRC_SE: begin
          d.pdat[j] = i_se_data[j];
        end
        sic_pkg::SRC_BUS: begin
          d.pdat[j] = q.ocfg[j][sic_pkg::F_OB];
        end
        sic_pkg::SRC_CLK: begin
          d.pdat[j] = d.clk100;
        end
        default: begin
          d.pdat[j] = 1'b0;
        end
      endcase
      if (!d.act) begin
        d.pdat[j] = 1'b0;
      end
    end

    // ****************************************************
    // bus write: address and data taken in either order
    // ****************************************************
    if (i_awvalid && !q.awh && !q.bv) begin
      d.awh = 1'b1;
      d.awa = i_awaddr;
    end
    if (i_wvalid && !q.wh && !q.bv) begin
      d.wh = 1'b1;
      d.wd = i_wdata;
      d.ws = i_wstrb;
    end
    if (q.bv && i_bready) begin
      d.bv = 1'b0;
    end
    if (q.awh && q.wh) begin
      d.awh = 1'b0;
      d.wh  = 1'b0;
      d.bv  = 1'b1;
      d.br  = sic_pkg::R_SLV;
      if (q.awa[7:2] == sic_pkg::A_CTRL[7:2]) begin
        w     = merge({31'h0, q.ctl}, q.wd, q.ws);
        d.ctl = w[0];
        d.br  = sic_pkg::R_OKAY;
      end
      h = hit(q.awa, sic_pkg::A_INCFG, sic_pkg::N_IN);
      if (h[4]) begin
        d.icfg[h[3:0]] = merge(q.icfg[h[3:0]], q.wd, q.ws);
        d.br           = sic_pkg::R_OKAY;
      end
      h = hit(q.awa, sic_pkg::A_PWID, sic_pkg::N_VX);
      if (h[4]) begin
        w = merge({25'h0, q.pw[h[3:0]]}, q.wd, q.ws);
        d.pw[h[3:0]] = (w[6:0] > 7'(sic_pkg::PW_MAX_US)) ?
                       7'(sic_pkg::PW_MAX_US) : w[6:0];
        d.br = sic_pkg::R_OKAY;
      end
      h = hit(q.awa, sic_pkg::A_OUTCFG, sic_pkg::N_PDO);
      if (h[4]) begin
        w = merge({23'h0, q.ocfg[h[3:0]]}, q.wd, q.ws);
        d.ocfg[h[3:0]] = w[8:0];
        d.br           = sic_pkg::R_OKAY;
      end
    end

    // ****************************************************
    // bus read
    // ****************************************************
    if (q.rv && i_rready) begin
      d.rv = 1'b0;
    end
    if (i_arvalid && !q.rv) begin
      d.rv = 1'b1;
      d.rr = sic_pkg::R_SLV;
      d.rd = 32'h0000_0000;
      if (i_araddr[7:2] == sic_pkg::A_CTRL[7:2]) begin
        d.rd = {31'h0, q.ctl};
        d.rr = sic_pkg::R_OKAY;
      end
      if (i_araddr[7:2] == sic_pkg::A_STAT[7:2]) begin
        d.rd = {10'h000, q.act, q.wany, q.lo, q.wrn, q.flt}; // RULE12
        d.rr = sic_pkg::R_OKAY;
      end
      h = hit(i_araddr, sic_pkg::A_INCFG, sic_pkg::N_IN);
      if (h[4]) begin
        d.rd = q.icfg[h[3:0]];
        d.rr = sic_pkg::R_OKAY;
      end
      h = hit(i_araddr, sic_pkg::A_PWID, sic_pkg::N_VX);
      if (h[4]) begin
        d.rd = {25'h0, q.pw[h[3:0]]};
        d.rr = sic_pkg::R_OKAY;
      end
      h = hit(i_araddr, sic_pkg::A_OUTCFG, sic_pkg::N_PDO);
      if (h[4]) begin
        d.rd = {23'h0, q.ocfg[h[3:0]]};
        d.rr = sic_pkg::R_OKAY;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0; // RULE21
    end else begin
      q <= d;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign o_awready  = ~q.awh & ~q.bv;
  assign o_wready   = ~q.wh & ~q.bv;
  assign o_bvalid   = q.bv;
  assign o_bresp    = q.br;
  assign o_arready  = ~q.rv;
  assign o_rvalid   = q.rv;
  assign o_rdata    = q.rd;
  assign o_rresp    = q.rr;
  assign o_uv_thr   = q.uvt;
  assign o_ov_thr   = q.ovt;
  assign o_fault    = q.flt;
  assign o_warn     = q.wrn;
  assign o_warn_any = q.wany;
  assign o_logic    = q.lo;
  assign o_vx_pd    = q.pd;
  assign o_pdo_mode = q.pm;
  assign o_pdo_data = q.pdat;

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  property p_uv_hy;
    q.fo[0] && $past(q.fo[0]) && $stable(q.icfg[0]) |->
      q.uvt[0] == sadd(q.icfg[0][7:0], q.icfg[0][20:16]);
  endproperty
  a_uv_hy: assert property (p_uv_hy) // RULE1
    else $error("uv threshold lacks hysteresis");

  property p_ov_hy;
    !q.fo[10] && $past(!q.fo[10]) && $stable(q.icfg[0]) |->
      q.ovt[0] == q.icfg[0][15:8];
  endproperty
  a_ov_hy: assert property (p_ov_hy) // RULE2
    else $error("ov threshold shifted without fault");

  property p_filt;
    $changed(q.fo[0]) |-> $past(q.fc[0]) >= $past(lim(q.icfg[0]));
  endproperty
  a_filt: assert property (p_filt) // RULE6
    else $error("filter output moved before timeout");

  property p_nofilt;
    lim(q.icfg[1]) == 7'h00 && $stable(q.icfg[1]) &&
      q.s2[1] != q.fo[1] |=> q.fo[1] == $past(q.s2[1]);
  endproperty
  a_nofilt: assert property (p_nofilt) // RULE5
    else $error("zero timeout did not pass through");

  property p_excl;
    $past(q.icfg[5][28]) |-> !q.flt[5];
  endproperty
  a_excl: assert property (p_excl) // RULE24
    else $error("logic input still flags a fault");

  property p_warn;
    q.wany == (|q.wrn);
  endproperty
  a_warn: assert property (p_warn) // RULE12
    else $error("warning summary mismatch");

  property p_edge;
    $past(q.icfg[7][29] && q.icfg[7][28]) && $rose(q.lo[2]) |->
      $past(q.fo[22]) != $past(q.fo[22], 2);
  endproperty
  a_edge: assert property (p_edge) // RULE15
    else $error("edge pulse without transition");

  property p_dflt;
    !q.act |-> (q.pm == '0) && (q.pdat == '0);
  endproperty
  a_dflt: assert property (p_dflt) // RULE22
    else $error("output driven before configuration");

  property p_hd;
    q.pm[6] != sic_pkg::PM_HD && q.pm[9] != sic_pkg::PM_HD;
  endproperty
  a_hd: assert property (p_hd) // RULE18
    else $error("high drive on an output without it");

  property p_clk;
    $changed(q.clk100) |-> $past(q.ck) == 8'(sic_pkg::OCLK_HALF - 1);
  endproperty
  a_clk: assert property (p_clk) // RULE20
    else $error("on-chip clock half period wrong");

  property p_bhold;
    q.bv && !i_bready |=> q.bv && $stable(q.br);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped early");

  c_uv:   cover property ($rose(q.fo[0]));
  c_warn: cover property ($rose(q.wany));
  c_edge: cover property ($fell(q.lo[2]));
  c_clk:  cover property (q.act && $changed(q.pdat[0]));

endmodule

// *** rail_model.sv ***
// supply rail model: turns rail levels into comparator flags
`timescale 1ns/1ps
module rail_model (
  input  wire logic [9:0][7:0] i_level,
  input  wire logic [9:0][7:0] i_uv_thr,
  input  wire logic [9:0][7:0] i_ov_thr,
  output logic      [9:0]      o_uv_cmp,
  output logic      [9:0]      o_ov_cmp
);
  // ****************************************
  // comparators, instant like the analog part
  // ****************************************
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      o_uv_cmp[i] = i_level[i] < i_uv_thr[i];
      o_ov_cmp[i] = i_level[i] > i_ov_thr[i];
    end
  end
endmodule

// *** testbench.sv ***
// self-checking bench for the supply input conditioning block
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [8:0] cfg;
    logic [2:0] m;
    logic       d;
  } row_s;
  logic            clk, rst_n, sok, b;
  logic            awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]      awaddr, araddr;
  logic [31:0]     wdata, rdata, d;
  logic [3:0]      wstrb;
  logic [4:0]      vx, warn, lg, pd;
  logic [9:0]      se, uvc, ovc, fault, pdata;
  logic [9:0][7:0] lvl, uvt, ovt;
  logic [9:0][2:0] pmode;
  logic            awready, wready, bvalid, arready, rvalid, warn_any;
  logic [1:0]      bresp, rresp, r;
  int              n_mismatch, comparisons, n, h, p;
  row_s            rows [10];

  supply_input_conditioning uut (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .i_uv_cmp(uvc), .i_ov_cmp(ovc), .i_vx_pin(vx),
    .i_supply_ok(sok), .i_se_data(se), .o_uv_thr(uvt), .o_ov_thr(ovt),
    .o_fault(fault), .o_warn(warn), .o_warn_any(warn_any),
    .o_logic(lg), .o_vx_pd(pd), .o_pdo_mode(pmode), .o_pdo_data(pdata));
  rail_model rm (.i_level(lvl), .i_uv_thr(uvt), .i_ov_thr(ovt),
    .o_uv_cmp(uvc), .o_ov_cmp(ovc));

  always #12.5 clk = ~clk;

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic hang();
    n_mismatch++;
    test_done();
  endtask

  function automatic logic [7:0] ic(input int i);
    return sic_pkg::A_INCFG + 8'(4 * i);
  endfunction

  // one write, aw and w offered together, bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    wstrb   <= 4'hF;
    bready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (k == 50) hang();
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (k == 50) hang();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wflt(input int i, input logic v);
    for (n = 0; n < 5000 && fault[i] !== v; n++) @(posedge clk);
    if (n == 5000) hang();
  endtask

  task automatic wpd();
    b = pdata[0];
    for (n = 0; n < 500 && pdata[0] === b; n++) @(posedge clk);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    hang();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clk = 1'b0; rst_n = 1'b0; sok = 1'b1; vx = 5'h00; se = 10'h202;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    wstrb = 4'h0; lvl = {10{8'h90}}; n_mismatch = 0; comparisons = 0;
    rows = '{'{9'h110, 3'h0, 1'b1}, '{9'h001, 3'h1, 1'b1},
      '{9'h012, 3'h2, 1'b0}, '{9'h113, 3'h3, 1'b1},
      '{9'h004, 3'h4, 1'b0}, '{9'h116, 3'h6, 1'b1},
      '{9'h116, 3'h0, 1'b1}, '{9'h117, 3'h0, 1'b1},
      '{9'h015, 3'h5, 1'b0}, '{9'h005, 3'h5, 1'b1}};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // output rows: held off until configuration is latched
    for (int i = 0; i < 10; i++)
      wr(sic_pkg::A_OUTCFG + 8'(4 * i), 32'(rows[i].cfg));
    repeat (4) @(posedge clk);
    chk(32'(pmode), 32'h0);
    wr(sic_pkg::A_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      chk(32'(pmode[i]), 32'(rows[i].m));
      chk(32'(pdata[i]), 32'(rows[i].d));
    end
    $display("output select rows done");
    wr(sic_pkg::A_OUTCFG, 32'h20);
    // let the source switch settle so only clock toggles are timed
    repeat (2) @(posedge clk);
    wpd();
    wpd();
    chk(n, 200);
    sok <= 1'b0;
    repeat (6) @(posedge clk);
    chk(32'(pmode), 32'h0);
    sok <= 1'b1;
    $display("clock and latch done");
    // undervoltage hysteresis; filter kept nonzero on the first input
    wr(ic(0), 32'h0024FF80);
    wflt(0, 1'b0);
    lvl[0] <= 8'h7F;
    wflt(0, 1'b1);
    repeat (4) @(posedge clk);
    chk(32'(uvt[0]), 32'h84);
    lvl[0] <= 8'h83;
    repeat (400) @(posedge clk);
    chk(32'(fault[0]), 32'h1);
    lvl[0] <= 8'h85;
    wflt(0, 1'b0);
    repeat (4) @(posedge clk);
    chk(32'(uvt[0]), 32'h80);
    // overvoltage hysteresis at the largest code
    lvl[1] <= 8'h10;
    wr(ic(1), 32'h001F4000);
    wflt(1, 1'b0);
    lvl[1] <= 8'h41;
    wflt(1, 1'b1);
    repeat (4) @(posedge clk);
    chk(32'(ovt[1]), 32'h21);
    lvl[1] <= 8'h22;
    repeat (100) @(posedge clk);
    chk(32'(fault[1]), 32'h1);
    lvl[1] <= 8'h20;
    wflt(1, 1'b0);
    $display("hysteresis done");
    // glitch filter of 5 us
    wr(ic(2), 32'h00A0FF80);
    wflt(2, 1'b0);
    lvl[2] <= 8'h70;
    repeat (120) @(posedge clk);
    lvl[2] <= 8'h90;
    d = 32'h0;
    repeat (400) begin
      @(posedge clk);
      d[0] = d[0] | fault[2];
    end
    chk(d, 32'h0);
    lvl[2] <= 8'h70;
    wflt(2, 1'b1);
    chk(32'(n >= 200 && n <= 250), 32'h1);
    lvl[2] <= 8'h90;
    wflt(2, 1'b0);
    chk(32'(n >= 200 && n <= 250), 32'h1);
    $display("glitch filter done");
    // dual inputs: level with pull-down on 1, edge on 3
    wr(ic(5), 32'h5000FF80);
    wr(ic(7), 32'h3000FF80);
    wr(sic_pkg::A_PWID + 8'h08, 32'h2);
    vx[0] <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(lg[0]), 32'h1);
    chk(32'(pd), 32'h01);
    vx[0] <= 1'b0;
    lvl[5] <= 8'h70;
    repeat (10) @(posedge clk);
    chk(32'(lg[0]), 32'h0);
    chk(32'(fault[5]), 32'h0);
    chk(32'(warn), 32'h01);
    chk(32'(warn_any), 32'h1);
    rd(sic_pkg::A_STAT);
    chk(32'(d[20:10]), 32'h401);
    h = 0;
    p = 0;
    b = 1'b0;
    vx[2] <= 1'b1;
    for (int c = 0; c < 600; c++) begin
      if (c == 300) vx[2] <= 1'b0;
      @(posedge clk);
      h += int'(lg[2] === 1'b1);
      p += int'(lg[2] === 1'b1 && b !== 1'b1);
      b = lg[2];
    end
    chk(p, 2);
    chk(32'(h >= 160 && h <= 240), 32'h1);
    $display("dual inputs done");
    // bus refusals and clamp
    rd(8'h3C);
    chk(32'(r), 32'(sic_pkg::R_SLV));
    chk(d, 32'h0);
    wr(sic_pkg::A_STAT, 32'hFFFFFFFF);
    chk(32'(r), 32'(sic_pkg::R_SLV));
    wr(sic_pkg::A_PWID, 32'h7F);
    rd(sic_pkg::A_PWID);
    chk(d, 32'h64);
    // second reset: control and entry 0 of each config table read back as zero
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(pmode), 32'h0);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(8'(i * 64));
      chk(d, 32'h0);
    end
    $display("reset checks done");
    test_done();
  end
endmodule
